// [foc_pkg.sv]
// package with register map, field positions, reset values and timing counts
package foc_pkg;
  // register offsets (8-bit register index, byte address is four times it)
  localparam logic [7:0] IDX_TIMER_STATUS = 8'h79;
  localparam logic [7:0] IDX_ASSERT_LIMIT = 8'h7A;
  localparam logic [7:0] IDX_PULSES_PER_REV = 8'h7B;
  localparam logic [7:0] IDX_CONFIG_FIVE = 8'h7C;
  localparam logic [7:0] IDX_CONFIG_FOUR = 8'h7D;
  localparam logic [7:0] IDX_FACTORY_ONE = 8'h7E;
  localparam logic [7:0] IDX_FACTORY_TWO = 8'h7F;
  // registers of our own for status, mask, lock, limits and aux output
  localparam logic [7:0] IDX_INT_STATUS2 = 8'h42;
  localparam logic [7:0] IDX_INT_MASK2 = 8'h75;
  localparam logic [7:0] IDX_LOCK = 8'h40;
  localparam logic [7:0] IDX_OT_LIMIT_R1 = 8'h6A;
  localparam logic [7:0] IDX_OT_LIMIT_LOC = 8'h6B;
  localparam logic [7:0] IDX_OT_LIMIT_R2 = 8'h6C;
  localparam logic [7:0] IDX_AUX_OUT = 8'h41;
  // reset values
  localparam logic [7:0] RST_ASSERT_LIMIT = 8'h00;
  localparam logic [7:0] RST_PULSES_PER_REV = 8'h55;
  localparam logic [7:0] RST_CONFIG_FIVE = 8'h01;
  localparam logic [7:0] RST_CONFIG_FOUR = 8'h00;
  localparam logic [7:0] RST_FACTORY = 8'h00;
  localparam logic [7:0] RST_OT_LIMIT = 8'h7F;
  // field positions
  localparam int FLD_PULSE_COUNT_FOURTH_FAULT = 5;
  localparam int FLD_SIGNED_FMT = 0;
  localparam int FLD_OFFSET_RANGE = 1;
  localparam int FLD_AUX_DIR = 2;
  localparam int FLD_AUX_POL = 3;
  localparam int FLD_VID_SEL = 4;
  localparam int FLD_R1_OUT = 5;
  localparam int FLD_LOC_OUT = 6;
  localparam int FLD_R2_OUT = 7;
  localparam int FLD_OT_OFF = 2;
  localparam int FLD_FAN_TARGET = 3;
  localparam int FLD_BYPASS_LO = 4;
  localparam int FLD_LOCK = 1;
  // shared pin function codes
  localparam logic [1:0] PIN_PULSE_COUNT_FOURTH_SPEED = 2'h0;
  localparam logic [1:0] PIN_OVERTEMP = 2'h1;
  localparam logic [1:0] PIN_BUS_ALERT = 2'h2;
  localparam logic [1:0] PIN_AUX_IO = 2'h3;
  // disabled limit codes per format
  localparam logic [7:0] LIMIT_OFF_OFFSET64 = 8'h00;
  localparam logic [7:0] LIMIT_OFF_SIGNED = 8'h80;
  // timer step: 22.76 ms at 100 MHz
  localparam int CLK_MHZ = 100;
  localparam int STEP_US = 22760;
  localparam int STEP_CYCLES = STEP_US * CLK_MHZ;
endpackage

// [foc_assert_timer.sv]
// overtemperature assertion timer with limit compare
`timescale 1ns/10ps
`default_nettype none
module foc_assert_timer #(
  parameter int STEP_CYCLES = foc_pkg::STEP_CYCLES
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic asserted,
  input wire logic [7:0] limit,
  output logic [7:0] count,
  output logic limit_hit
);
  logic [31:0] prescale;
  logic was_asserted;
  logic step;

  assign step = asserted && (prescale == 32'(STEP_CYCLES - 1));

  // prescaler restarts on each new assertion
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      prescale <= 32'h0;
    else if (!asserted || step)
      prescale <= 32'h0;
    else
      prescale <= prescale + 32'h1;
  end

  // count saturates at full scale rather than wrapping
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      count <= 8'h00;
    else if (asserted && !was_asserted)
      count <= 8'h00;
    else if (step && count != 8'hFF)
      count <= count + 8'h01;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      was_asserted <= 1'b0;
    else
      was_asserted <= asserted;
  end

  // zero limit fires on the assertion itself
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      limit_hit <= 1'b0;
    else
      limit_hit <= asserted && ((limit == 8'h00) || (count > limit));
  end
endmodule
`default_nettype wire

// [foc_regs.sv]
// fan and overtemperature configuration register bank on apb
//
// Contract
// - 8-bit limit, lsb 22.76 ms
// - over-limit assertion sets pulse_count_fourth fault flag
// - zero limit raises flag on assertion
// - four 2-bit pulse counts, reset 0x55
// - bit0 selects signed format, reset 0x01
// - offset range bit selects offset resolution
// - aux pin direction bit: 0 in, 1 out
// - aux pin polarity bit for output level
// - voltage id select: id inputs or gpio
// - per-channel overtemp output enables
// - minimum limit code disables channel
// - two bits pick shared pin function
// - output-off bit disables all overtemp outputs; code gates only overtemp_pin_oe, fan outputs still follow any_over
// - fan target full or programmed maximum
// - four attenuator bypass bits
// - config four and five locked read-only
// - timer count in upper seven bits
// - mask bit 5 suppresses alert
//
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module foc_regs (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic shared_pin_in,
  input wire logic [2:0] channel_over,
  output logic overtemp_pin_out,
  output logic overtemp_pin_oe,
  output logic aux_io_pin_out,
  output logic aux_io_pin_oe,
  output logic bus_alert_out,
  output logic fan_full_speed,
  output logic fan_to_max_duty,
  output logic [7:0] fan_pulses_per_rev,
  output logic signed_temp_format,
  output logic offset_range_sel,
  output logic voltage_id_select,
  output logic [3:0] attenuator_bypass,
  output logic [1:0] shared_pin_function
);
  logic [7:0] overtemp_assert_limit;
  logic [7:0] pulses_reg;
  logic [7:0] config_five;
  logic [7:0] config_four;
  logic [7:0] int_status2;
  logic [7:0] int_mask2;
  logic [7:0] lock_reg;
  logic [7:0] aux_out_reg;
  logic [7:0] ot_limit [3];
  logic [7:0] timer_status;
  logic pin_meta;
  logic pin_sync;
  logic overtemp_asserted;
  logic [7:0] assert_timer_count;
  logic limit_hit;
  logic limit_hit_d;
  logic [7:0] idx;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic locked;
  logic [7:0] wbyte;
  logic [7:0] next_rdata;
  logic [2:0] chan_enabled;
  logic any_over;
  logic status_read;

  assign idx = paddr[9:2];
  assign wbyte = pwdata[7:0];
  assign wr_en = psel && penable && pwrite && pstrb[0];
  assign rd_en = psel && penable && !pwrite;
  assign locked = lock_reg[foc_pkg::FLD_LOCK];
  assign status_read = rd_en && addr_ok && idx == foc_pkg::IDX_TIMER_STATUS;

  // unmapped and misaligned accesses answer with an error
  always_comb
  begin
    addr_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    if (idx == foc_pkg::IDX_TIMER_STATUS || idx == foc_pkg::IDX_ASSERT_LIMIT)
      addr_ok = addr_ok;
    else if (idx == foc_pkg::IDX_PULSES_PER_REV || idx == foc_pkg::IDX_CONFIG_FIVE)
      addr_ok = addr_ok;
    else if (idx == foc_pkg::IDX_CONFIG_FOUR || idx == foc_pkg::IDX_FACTORY_ONE)
      addr_ok = addr_ok;
    else if (idx == foc_pkg::IDX_FACTORY_TWO || idx == foc_pkg::IDX_INT_STATUS2)
      addr_ok = addr_ok;
    else if (idx == foc_pkg::IDX_INT_MASK2 || idx == foc_pkg::IDX_LOCK)
      addr_ok = addr_ok;
    else if (idx == foc_pkg::IDX_AUX_OUT)
      addr_ok = addr_ok;
    else if (idx >= foc_pkg::IDX_OT_LIMIT_R1 && idx <= foc_pkg::IDX_OT_LIMIT_R2)
      addr_ok = addr_ok;
    else
      addr_ok = 1'b0;
  end

  // plain writable registers
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      overtemp_assert_limit <= foc_pkg::RST_ASSERT_LIMIT;
      pulses_reg <= foc_pkg::RST_PULSES_PER_REV;
      int_mask2 <= 8'h00;
      aux_out_reg <= 8'h00;
    end
    else if (wr_en && addr_ok)
    begin
      if (idx == foc_pkg::IDX_ASSERT_LIMIT)
        overtemp_assert_limit <= wbyte;
      else if (idx == foc_pkg::IDX_PULSES_PER_REV)
        pulses_reg <= wbyte;
      else if (idx == foc_pkg::IDX_INT_MASK2)
        int_mask2 <= wbyte;
      else if (idx == foc_pkg::IDX_AUX_OUT)
        aux_out_reg <= {7'h00, wbyte[0]};
    end
  end

  // lock is sticky until reset, so software cannot undo it
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      lock_reg <= 8'h00;
    else if (wr_en && addr_ok && idx == foc_pkg::IDX_LOCK && wbyte[foc_pkg::FLD_LOCK])
      lock_reg <= 8'h02;
  end

  // locked configuration ignores writes silently
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      config_five <= foc_pkg::RST_CONFIG_FIVE;
      config_four <= foc_pkg::RST_CONFIG_FOUR;
    end
    else if (wr_en && addr_ok && !locked)
    begin
      if (idx == foc_pkg::IDX_CONFIG_FIVE)
        config_five <= wbyte;
      else if (idx == foc_pkg::IDX_CONFIG_FOUR)
        config_four <= wbyte;
    end
  end

  // per-channel overtemperature limits
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_lim
      always_ff @(posedge core_clk or negedge rstn)
      begin
        if (!rstn)
          ot_limit[g] <= foc_pkg::RST_OT_LIMIT;
        else if (wr_en && addr_ok && idx == foc_pkg::IDX_OT_LIMIT_R1 + 8'(g))
          ot_limit[g] <= wbyte;
      end
      // minimum code of the active format switches the channel off
      assign chan_enabled[g] = config_five[foc_pkg::FLD_R1_OUT + g] &&
        (ot_limit[g] != (config_five[foc_pkg::FLD_SIGNED_FMT] ?
          foc_pkg::LIMIT_OFF_SIGNED : foc_pkg::LIMIT_OFF_OFFSET64));
    end
  endgenerate

  // shared pin is asynchronous, two flops before use
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
    end
    else
    begin
      pin_meta <= shared_pin_in;
      pin_sync <= pin_meta;
    end
  end

  // overtemp pin is active low and only counts when selected
  assign overtemp_asserted = (config_four[1:0] == foc_pkg::PIN_OVERTEMP) && !pin_sync;
  assign any_over = |(channel_over & chan_enabled);

  foc_assert_timer #(
    .STEP_CYCLES(foc_pkg::STEP_CYCLES)
  ) u_timer (
    .core_clk(core_clk),
    .rstn(rstn),
    .asserted(overtemp_asserted),
    .limit(overtemp_assert_limit),
    .count(assert_timer_count),
    .limit_hit(limit_hit)
  );

  // timer status: bit0 sticky until read, upper bits hold the count
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      timer_status <= 8'h00;
    else
    begin
      timer_status[7:1] <= assert_timer_count[7:1];
      if (overtemp_asserted || assert_timer_count[0])
        timer_status[0] <= 1'b1;
      else if (status_read)
        timer_status[0] <= 1'b0;
    end
  end

  // fault flag: a new hit wins over a clearing read
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      int_status2 <= 8'h00;
      limit_hit_d <= 1'b0;
    end
    else
    begin
      limit_hit_d <= limit_hit;
      if (limit_hit && !limit_hit_d)
        int_status2[foc_pkg::FLD_PULSE_COUNT_FOURTH_FAULT] <= 1'b1;
      else if (rd_en && addr_ok && idx == foc_pkg::IDX_INT_STATUS2)
        int_status2[foc_pkg::FLD_PULSE_COUNT_FOURTH_FAULT] <= 1'b0;
    end
  end

  // read mux; factory test words read as zero
  always_comb
  begin
    next_rdata = 8'h00;
    if (idx == foc_pkg::IDX_TIMER_STATUS)
      next_rdata = timer_status;
    else if (idx == foc_pkg::IDX_ASSERT_LIMIT)
      next_rdata = overtemp_assert_limit;
    else if (idx == foc_pkg::IDX_PULSES_PER_REV)
      next_rdata = pulses_reg;
    else if (idx == foc_pkg::IDX_CONFIG_FIVE)
      next_rdata = config_five;
    else if (idx == foc_pkg::IDX_CONFIG_FOUR)
      next_rdata = config_four;
    else if (idx == foc_pkg::IDX_FACTORY_ONE || idx == foc_pkg::IDX_FACTORY_TWO)
      next_rdata = foc_pkg::RST_FACTORY;
    else if (idx == foc_pkg::IDX_INT_STATUS2)
      next_rdata = int_status2;
    else if (idx == foc_pkg::IDX_INT_MASK2)
      next_rdata = int_mask2;
    else if (idx == foc_pkg::IDX_LOCK)
      next_rdata = lock_reg;
    else if (idx == foc_pkg::IDX_AUX_OUT)
      next_rdata = aux_out_reg;
    else if (idx >= foc_pkg::IDX_OT_LIMIT_R1 && idx <= foc_pkg::IDX_OT_LIMIT_R2)
      next_rdata = ot_limit[2'(idx - foc_pkg::IDX_OT_LIMIT_R1)];
  end

  // zero-wait slave: answer in the access cycle
  always_comb
  begin
    pready = 1'b1;
    pslverr = psel && penable && !addr_ok;
    prdata = {24'h000000, (rd_en && addr_ok) ? next_rdata : 8'h00};
  end

  // pin drivers, all registered
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      overtemp_pin_out <= 1'b1;
      overtemp_pin_oe <= 1'b0;
      aux_io_pin_out <= 1'b0;
      aux_io_pin_oe <= 1'b0;
      bus_alert_out <= 1'b1;
      fan_full_speed <= 1'b0;
      fan_to_max_duty <= 1'b0;
    end
    else
    begin
      // open-drain low while overtemp function selected, any enabled channel is over and output not off
      overtemp_pin_out <= 1'b0;
      overtemp_pin_oe <= (config_four[1:0] == foc_pkg::PIN_OVERTEMP) && any_over &&
        !config_four[foc_pkg::FLD_OT_OFF];
      aux_io_pin_out <= aux_out_reg[0] ~^ config_five[foc_pkg::FLD_AUX_POL];
      aux_io_pin_oe <= (config_four[1:0] == foc_pkg::PIN_AUX_IO) &&
        config_five[foc_pkg::FLD_AUX_DIR];
      // alert is active low, the mask bit holds it off
      bus_alert_out <= !(int_status2[foc_pkg::FLD_PULSE_COUNT_FOURTH_FAULT] &&
        !int_mask2[foc_pkg::FLD_PULSE_COUNT_FOURTH_FAULT]);
      fan_full_speed <= any_over && !config_four[foc_pkg::FLD_FAN_TARGET];
      fan_to_max_duty <= any_over && config_four[foc_pkg::FLD_FAN_TARGET];
    end
  end

  // configuration fields out to the measurement logic
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      fan_pulses_per_rev <= foc_pkg::RST_PULSES_PER_REV;
      signed_temp_format <= foc_pkg::RST_CONFIG_FIVE[foc_pkg::FLD_SIGNED_FMT];
      offset_range_sel <= 1'b0;
      voltage_id_select <= 1'b0;
      attenuator_bypass <= 4'h0;
      shared_pin_function <= foc_pkg::PIN_PULSE_COUNT_FOURTH_SPEED;
    end
    else
    begin
      fan_pulses_per_rev <= pulses_reg;
      signed_temp_format <= config_five[foc_pkg::FLD_SIGNED_FMT];
      offset_range_sel <= config_five[foc_pkg::FLD_OFFSET_RANGE];
      voltage_id_select <= config_five[foc_pkg::FLD_VID_SEL];
      attenuator_bypass <= config_four[7:4];
      shared_pin_function <= config_four[1:0];
    end
  end

  // assertions
  property p_lock_holds;
    @(posedge core_clk) disable iff (!rstn)
    locked |=> $stable(config_five) && $stable(config_four);
  endproperty
  a_lock_holds: assert property (p_lock_holds) else $error("locked config changed");

  property p_hit_sets_flag;
    @(posedge core_clk) disable iff (!rstn)
    $rose(limit_hit) |=> int_status2[5];
  endproperty
  a_hit_sets_flag: assert property (p_hit_sets_flag) else $error("fault flag not set");

  sequence s_zero_assert;
    overtemp_assert_limit == 8'h00 && overtemp_asserted;
  endsequence
  property p_zero_limit;
    @(posedge core_clk) disable iff (!rstn)
    s_zero_assert |=> limit_hit;
  endproperty
  a_zero_limit: assert property (p_zero_limit) else $error("zero limit did not fire");

  property p_factory_zero;
    @(posedge core_clk) disable iff (!rstn)
    rd_en && (idx == 8'h7E || idx == 8'h7F) |-> prdata == 32'h00000000;
  endproperty
  a_factory_zero: assert property (p_factory_zero) else $error("factory register nonzero");

  property p_off_no_drive;
    @(posedge core_clk) disable iff (!rstn)
    config_four[2] |=> !overtemp_pin_oe;
  endproperty
  a_off_no_drive: assert property (p_off_no_drive) else $error("overtemp driven while off");

  property p_aux_dir;
    @(posedge core_clk) disable iff (!rstn)
    !config_five[2] |=> !aux_io_pin_oe;
  endproperty
  a_aux_dir: assert property (p_aux_dir) else $error("aux driven as input");

  property p_mask_alert;
    @(posedge core_clk) disable iff (!rstn)
    int_mask2[5] |=> bus_alert_out;
  endproperty
  a_mask_alert: assert property (p_mask_alert) else $error("masked alert asserted");

  property p_fan_target;
    @(posedge core_clk) disable iff (!rstn)
    any_over |=> fan_full_speed != fan_to_max_duty;
  endproperty
  a_fan_target: assert property (p_fan_target) else $error("fan target wrong");
endmodule
`default_nettype wire

// [testbench.sv]
// self-checking bench for the fan and overtemperature register bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [2:0] channel_over = 3'h0;
  logic pin_drive = 1'b1;
  logic [31:0] prdata;
  logic pready, pslverr, ot_out, ot_oe, aux_out, aux_oe, alert_n, fan_full, fan_max, fmt, rng, voltage_id_code;
  logic [7:0] ppr;
  logic [3:0] byp;
  logic [1:0] pfn;
  wire shared_pin;
  int errors = 0;
  int checked = 0;
  logic [31:0] rd;
  logic er;
  logic [7:0] v;
  logic [7:0] tbl [8];

  // shared pin level: open-drain pull-down wins, then aux driver, else the bench
  assign shared_pin = ot_oe ? ot_out : (aux_oe ? aux_out : pin_drive);

  always #5 core_clk = ~core_clk;

  foc_regs u_dut (.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shared_pin_in(shared_pin), .channel_over(channel_over), .overtemp_pin_out(ot_out),
    .overtemp_pin_oe(ot_oe), .aux_io_pin_out(aux_out), .aux_io_pin_oe(aux_oe), .bus_alert_out(alert_n),
    .fan_full_speed(fan_full), .fan_to_max_duty(fan_max), .fan_pulses_per_rev(ppr),
    .signed_temp_format(fmt), .offset_range_sel(rng), .voltage_id_select(voltage_id_code),
    .attenuator_bypass(byp), .shared_pin_function(pfn));

  task automatic give_verdict;
    $display("summary: %0d comparisons, %0d mismatches", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      errors++;
      give_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check(rd, 32'(exp));
    check(32'(er), 32'h0);
  endtask

  // registered copies and pin synchronisers settle within a few cycles
  task automatic settle;
    repeat (6) @(posedge core_clk);
  endtask

  // watchdog against a hung run
  initial
  begin
    repeat (50000) @(posedge core_clk);
    errors++;
    give_verdict();
  end

  initial
  begin
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    // reset values of the bank
    rdc(foc_pkg::IDX_ASSERT_LIMIT, 8'h00);
    rdc(foc_pkg::IDX_PULSES_PER_REV, 8'h55);
    rdc(foc_pkg::IDX_CONFIG_FIVE, 8'h01);
    rdc(foc_pkg::IDX_CONFIG_FOUR, 8'h00);
    check(32'(ppr), 32'h55);
    check(32'(fmt), 32'h1);
    $display("test reset values done");
    // every pulse code in every fan field
    tbl = '{8'hE4, 8'h1B, 8'hFF, 8'h00, 8'h55, 8'hAA, 8'h39, 8'hC6};
    for (int i = 0; i < 8; i++)
    begin
      wr(foc_pkg::IDX_PULSES_PER_REV, tbl[i]);
      rdc(foc_pkg::IDX_PULSES_PER_REV, tbl[i]);
      settle();
      check(32'(ppr), 32'(tbl[i]));
    end
    wr(foc_pkg::IDX_ASSERT_LIMIT, 8'hFF);
    rdc(foc_pkg::IDX_ASSERT_LIMIT, 8'hFF);
    $display("test pulses and limit done");
    // walking one through config five
    for (int i = 0; i < 8; i++)
    begin
      v = 8'h01 << i;
      wr(foc_pkg::IDX_CONFIG_FIVE, v);
      rdc(foc_pkg::IDX_CONFIG_FIVE, v);
      settle();
      check(32'({fmt, rng, voltage_id_code}), 32'({v[0], v[1], v[4]}));
    end
    wr(foc_pkg::IDX_CONFIG_FIVE, 8'h01);
    // bypass bits and all four pin functions
    tbl = '{8'h10, 8'h20, 8'h40, 8'h80, 8'h01, 8'h02, 8'h03, 8'h00};
    for (int i = 0; i < 8; i++)
    begin
      wr(foc_pkg::IDX_CONFIG_FOUR, tbl[i]);
      rdc(foc_pkg::IDX_CONFIG_FOUR, tbl[i]);
      settle();
      check(32'({byp, pfn}), 32'({tbl[i][7:4], tbl[i][1:0]}));
    end
    $display("test config fields done");
    // factory registers ignore writes, unmapped place is refused
    wr(foc_pkg::IDX_FACTORY_ONE, 8'hFF);
    wr(foc_pkg::IDX_FACTORY_TWO, 8'hA5);
    rdc(foc_pkg::IDX_FACTORY_ONE, 8'h00);
    rdc(foc_pkg::IDX_FACTORY_TWO, 8'h00);
    wr(8'h10, 8'h5A);
    check(32'(er), 32'h1);
    apb(1'b0, 8'h10, 8'h00);
    check(32'(er), 32'h1);
    $display("test read-only and unmapped done");
    // zero limit: fault flag on assertion, alert masked
    wr(foc_pkg::IDX_ASSERT_LIMIT, 8'h00);
    wr(foc_pkg::IDX_INT_MASK2, 8'h20);
    wr(foc_pkg::IDX_CONFIG_FOUR, 8'h01);
    apb(1'b0, foc_pkg::IDX_INT_STATUS2, 8'h00);
    pin_drive <= 1'b0;
    settle();
    apb(1'b0, foc_pkg::IDX_INT_STATUS2, 8'h00);
    check(32'(rd[5]), 32'h1);
    check(32'(alert_n), 32'h1);
    apb(1'b0, foc_pkg::IDX_TIMER_STATUS, 8'h00);
    check(32'(rd[7:0]), 32'h01);
    pin_drive <= 1'b1;
    settle();
    apb(1'b0, foc_pkg::IDX_INT_STATUS2, 8'h00);
    apb(1'b0, foc_pkg::IDX_INT_STATUS2, 8'h00);
    check(32'(rd[5]), 32'h0);
    $display("test assertion flag done");
    // overtemperature output on the local channel
    channel_over <= 3'h2;
    wr(foc_pkg::IDX_CONFIG_FIVE, 8'h01);
    settle();
    check(32'(ot_oe), 32'h0);
    wr(foc_pkg::IDX_CONFIG_FIVE, 8'h41);
    settle();
    check(32'({ot_oe, ot_out, fan_full, fan_max}), 32'hA);
    wr(foc_pkg::IDX_CONFIG_FOUR, 8'h09);
    settle();
    check(32'({fan_full, fan_max}), 32'h1);
    wr(foc_pkg::IDX_CONFIG_FOUR, 8'h05);
    settle();
    check(32'(ot_oe), 32'h0);
    wr(foc_pkg::IDX_CONFIG_FOUR, 8'h01);
    wr(foc_pkg::IDX_OT_LIMIT_LOC, 8'h80);
    settle();
    check(32'(ot_oe), 32'h0);
    wr(foc_pkg::IDX_CONFIG_FIVE, 8'h40);
    settle();
    check(32'(ot_oe), 32'h1);
    wr(foc_pkg::IDX_OT_LIMIT_LOC, 8'h00);
    settle();
    check(32'(ot_oe), 32'h0);
    channel_over <= 3'h0;
    $display("test overtemperature output done");
    // aux pin direction and polarity
    wr(foc_pkg::IDX_CONFIG_FOUR, 8'h03);
    wr(foc_pkg::IDX_AUX_OUT, 8'h01);
    wr(foc_pkg::IDX_CONFIG_FIVE, 8'h0C);
    settle();
    check(32'({aux_oe, aux_out}), 32'h3);
    wr(foc_pkg::IDX_CONFIG_FIVE, 8'h04);
    settle();
    check(32'({aux_oe, aux_out}), 32'h2);
    wr(foc_pkg::IDX_CONFIG_FIVE, 8'h00);
    settle();
    check(32'(aux_oe), 32'h0);
    $display("test aux pin done");
    // lock freezes config four and five
    wr(foc_pkg::IDX_LOCK, 8'h02);
    wr(foc_pkg::IDX_CONFIG_FIVE, 8'hFF);
    wr(foc_pkg::IDX_CONFIG_FOUR, 8'hFC);
    rdc(foc_pkg::IDX_CONFIG_FIVE, 8'h00);
    rdc(foc_pkg::IDX_CONFIG_FOUR, 8'h03);
    $display("test lock done");
    // only a reset drops the lock; then the timer is driven through the pin
    rstn <= 1'b0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    rdc(foc_pkg::IDX_CONFIG_FOUR, 8'h00);
    wr(foc_pkg::IDX_CONFIG_FOUR, 8'h01);
    wr(foc_pkg::IDX_ASSERT_LIMIT, 8'h02);
    pin_drive <= 1'b0;
    // a full step is far beyond the run, so a nonzero limit never trips
    repeat (40) @(posedge core_clk);
    apb(1'b0, foc_pkg::IDX_INT_STATUS2, 8'h00);
    check(32'(rd[5]), 32'h0);
    apb(1'b0, foc_pkg::IDX_TIMER_STATUS, 8'h00);
    check(32'(rd[7:0]), 32'h01);
    check(32'(alert_n), 32'h1);
    pin_drive <= 1'b1;
    wr(foc_pkg::IDX_ASSERT_LIMIT, 8'h00);
    settle();
    pin_drive <= 1'b0;
    settle();
    check(32'(alert_n), 32'h0);
    apb(1'b0, foc_pkg::IDX_INT_STATUS2, 8'h00);
    check(32'(rd[5]), 32'h1);
    $display("test timer done");
    give_verdict();
  end
endmodule
`default_nettype wire
